// ===== hdl/acyclic_param_ctrl.sv
// Acyclic parameter access checker and drive command word decoder.
// Assumes the Modbus front end delivers parsed requests and that a parameter
// table answers the size of a looked-up identifier combinationally, in the same clock cycle.

`timescale 1ns/10ps
`default_nettype none

module acyclic_param_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Settings from the parameter store
  input  wire logic        regs_per_param_select,
  input  wire logic        master_one_based,
  input  wire logic        cyclic_in_use,
  input  wire logic        cyclic_packing_enable,
  input  wire logic        run_source_from_bus,
  input  wire logic [3:0]  preset_selector,
  // Safety pins
  input  wire logic        safe_torque_in_a,
  input  wire logic        safe_torque_in_b,
  // Parsed Modbus request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_count,
  input  wire logic [31:0] req_wdata,
  // Parameter size lookup
  output logic      [15:0] lookup_id,
  input  wire logic        param_is_32,
  // Answer and parameter access
  output logic             resp_valid,
  output logic             resp_exception,
  output logic      [7:0]  resp_code,
  output logic             param_wr,
  output logic             param_rd,
  output logic      [15:0] param_id,
  output logic      [31:0] param_wdata,
  output logic             map_clear,
  // Drive command outputs
  output logic      [31:0] drive_command_word,
  output logic             drive_enable_param,
  output logic             run_forward_param,
  output logic             jog_param,
  output logic             run_reverse_param,
  output logic             direction_param,
  output logic             run_param,
  output logic             digital_ref_select_param,
  output logic      [3:0]  active_preset,
  output logic             trip_reset_param,
  output logic             external_safety_permit
);

  typedef struct packed {
    logic        busy;
    logic [7:0]  func;
    logic [7:0]  count;
    logic [31:0] wdata;
    logic [15:0] id;
    logic [7:0]  pre_code;
    logic        acyc_seen;
    logic        resp_valid;
    logic        resp_exc;
    logic [7:0]  resp_code;
    logic        wr;
    logic        rd;
    logic        clear;
    logic [15:0] cw;
    logic        cw_trip_prev;
    logic [2:0]  sto_a;
    logic [2:0]  sto_b;
    logic        permit;
    logic [7:0]  drv;
    logic [3:0]  preset;
    logic        trip;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic        dec_in_area;
  logic        dec_aligned;
  logic [15:0] dec_id;
  logic        func_ok;
  logic        too_short;
  logic        bus_ok;

  // Function codes that reach the parameter table
  function automatic logic func_known(input logic [7:0] f);
    return (f == acyc_pkg::FC_READ_HOLD) || (f == acyc_pkg::FC_WR_SINGLE) ||
           (f == acyc_pkg::FC_WR_MULTI)  || (f == acyc_pkg::FC_RW_MULTI);
  endfunction

  // Functions that carry write data
  function automatic logic func_writes(input logic [7:0] f);
    return (f == acyc_pkg::FC_WR_SINGLE) || (f == acyc_pkg::FC_WR_MULTI) ||
           (f == acyc_pkg::FC_RW_MULTI);
  endfunction

  localparam logic [15:0] CW_ID =
    16'(acyc_pkg::CW_MENU * acyc_pkg::ID_MENU_SCALE + acyc_pkg::CW_INDEX);

  param_addr_decode u_decode (
    .addr      (req_addr),
    .two_regs  (regs_per_param_select),
    .one_based (master_one_based),
    .in_area   (dec_in_area),
    .aligned   (dec_aligned),
    .param_id  (dec_id)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // Two-stage request pipe: decode, then size check one cycle later
  always_comb begin
    next_s            = s;
    next_s.resp_valid = 1'b0;
    next_s.wr         = 1'b0;
    next_s.rd         = 1'b0;
    next_s.clear      = 1'b0;
    func_ok           = func_known(req_func);
    // One register is only 16 bits wide, so single-register mode is short
    too_short = (s.func == acyc_pkg::FC_WR_SINGLE) ||
                !regs_per_param_select ||
                (s.count < acyc_pkg::REGS_FOR_32);
    bus_ok = run_source_from_bus;
    if (req_valid && req_ready) begin
      next_s.busy  = 1'b1;
      next_s.func  = req_func;
      next_s.count = req_count;
      next_s.wdata = req_wdata;
      next_s.id    = dec_id;
      if (!func_ok) begin
        next_s.pre_code = acyc_pkg::EXC_ILL_FUNC;
      end else if (!dec_in_area || !dec_aligned) begin
        next_s.pre_code = acyc_pkg::EXC_ILL_ADDR;
      end else begin
        next_s.pre_code = acyc_pkg::EXC_NONE;
      end
    end else if (s.busy) begin
      next_s.busy       = 1'b0;
      next_s.resp_valid = 1'b1;
      if (s.pre_code != acyc_pkg::EXC_NONE) begin
        next_s.resp_exc  = 1'b1;
        next_s.resp_code = s.pre_code;
      end else if (param_is_32 && too_short) begin
        next_s.resp_exc  = 1'b1;
        next_s.resp_code = acyc_pkg::EXC_ILL_VALUE;
      end else begin
        next_s.resp_exc  = 1'b0;
        next_s.resp_code = acyc_pkg::EXC_NONE;
        next_s.wr        = func_writes(s.func);
        next_s.rd        = (s.func == acyc_pkg::FC_READ_HOLD) ||
                           (s.func == acyc_pkg::FC_RW_MULTI);
        // Outbound mapping is wiped once, only when cyclic data is idle
        if (!s.acyc_seen && !cyclic_in_use) begin
          next_s.clear = 1'b1;
        end
        next_s.acyc_seen = 1'b1;
        // Upper half of a 32-bit write is reserved and dropped
        if (func_writes(s.func) && s.id == CW_ID) begin
          next_s.cw = s.wdata[acyc_pkg::CW_WIDTH-1:0];
        end
      end
    end

    // Three-stage pin sync, permit follows once stages two and three agree
    next_s.sto_a = {s.sto_a[1:0], safe_torque_in_a};
    next_s.sto_b = {s.sto_b[1:0], safe_torque_in_b};
    if ((s.sto_a[1] == s.sto_a[2]) && (s.sto_b[1] == s.sto_b[2])) begin
      next_s.permit = s.sto_a[2] && s.sto_b[2];
    end

    // Command word decode, gated by run source; enable, run and jog bits also by safety permit
    next_s.drv[0] = bus_ok && s.permit && s.cw[acyc_pkg::CW_ENABLE];
    next_s.drv[1] = bus_ok && s.permit && s.cw[acyc_pkg::CW_RUN_FWD];
    next_s.drv[2] = bus_ok && s.permit && s.cw[acyc_pkg::CW_JOG];
    next_s.drv[3] = bus_ok && s.permit && s.cw[acyc_pkg::CW_RUN_REV];
    next_s.drv[4] = bus_ok && s.cw[acyc_pkg::CW_DIR];
    next_s.drv[5] = bus_ok && s.permit && s.cw[acyc_pkg::CW_RUN];
    next_s.drv[6] = bus_ok && s.cw[acyc_pkg::CW_REF_SEL];
    next_s.drv[7] = 1'b0;
    // Preset one unless the selector names another digital reference
    next_s.preset = (preset_selector == acyc_pkg::PRESET_SEL_OFF) ?
                    acyc_pkg::PRESET_DEFAULT : preset_selector;
    // Only the rising edge resets; a live fault will retrip by itself
    next_s.trip = bus_ok && s.cw[acyc_pkg::CW_TRIP_RST] && !s.cw_trip_prev;
    next_s.cw_trip_prev = s.cw[acyc_pkg::CW_TRIP_RST];
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s    <= '0;
      s.cw <= acyc_pkg::CW_RST_VALUE;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Ready is combinational so a new request can follow each answer
  assign req_ready                = !s.busy;
  assign lookup_id                = s.id;
  assign resp_valid               = s.resp_valid;
  assign resp_exception           = s.resp_exc;
  assign resp_code                = s.resp_code;
  assign param_wr                 = s.wr;
  assign param_rd                 = s.rd;
  assign param_id                 = s.id;
  assign param_wdata              = s.wdata;
  assign map_clear                = s.clear;
  assign drive_command_word       = cyclic_packing_enable ? {16'h0000, s.cw} :
                                    {16'h0000, s.cw};
  assign drive_enable_param       = s.drv[0];
  assign run_forward_param        = s.drv[1];
  assign jog_param                = s.drv[2];
  assign run_reverse_param        = s.drv[3];
  assign direction_param          = s.drv[4];
  assign run_param                = s.drv[5];
  assign digital_ref_select_param = s.drv[6];
  assign active_preset            = s.preset;
  assign trip_reset_param         = s.trip;
  assign external_safety_permit   = s.permit;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_fc06_wide_refused: assert property (@(posedge clk) disable iff (srst)
    (s.busy && s.pre_code == acyc_pkg::EXC_NONE && s.func == acyc_pkg::FC_WR_SINGLE
     && param_is_32) |=> (resp_exception && !param_wr))
    else $error("single write to 32-bit parameter not refused");

  chk_short_access_refused: assert property (@(posedge clk) disable iff (srst)
    (s.busy && s.pre_code == acyc_pkg::EXC_NONE && param_is_32 &&
     s.count < acyc_pkg::REGS_FOR_32) |=> (resp_valid && resp_code == acyc_pkg::EXC_ILL_VALUE))
    else $error("short access to 32-bit parameter not refused");

  chk_bad_func_answer: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_ready && !func_known(req_func)) |=>
      ##1 (resp_valid && resp_exception && resp_code == acyc_pkg::EXC_ILL_FUNC))
    else $error("unsupported function not answered with exception");

  chk_refused_no_write: assert property (@(posedge clk) disable iff (srst)
    resp_exception && resp_valid |-> !param_wr && !param_rd && !map_clear)
    else $error("refused request still touched a parameter");

  chk_map_clear_once: assert property (@(posedge clk) disable iff (srst)
    map_clear |-> (!$past(s.acyc_seen) && !$past(cyclic_in_use) && resp_valid && !resp_exception))
    else $error("mapping clear outside first accepted access");

  chk_start_needs_permit: assert property (@(posedge clk) disable iff (srst)
    (drive_enable_param || run_forward_param || run_reverse_param || run_param || jog_param)
      |-> $past(s.permit))
    else $error("drive started without safety permit");

  chk_bus_source_gate: assert property (@(posedge clk) disable iff (srst)
    !run_source_from_bus |=> !(drive_enable_param || direction_param || trip_reset_param))
    else $error("command word acted without fieldbus run source");

  chk_ref_select_copy: assert property (@(posedge clk) disable iff (srst)
    run_source_from_bus |=> digital_ref_select_param == $past(s.cw[acyc_pkg::CW_REF_SEL]))
    else $error("reference select not copied");

  chk_trip_edge_only: assert property (@(posedge clk) disable iff (srst)
    trip_reset_param |-> ($past(s.cw[acyc_pkg::CW_TRIP_RST]) && !$past(s.cw_trip_prev))
      ##1 !trip_reset_param)
    else $error("trip reset not a single rising-edge pulse");

endmodule

`default_nettype wire

// ===== common/acyc_pkg.sv
// Constants for the acyclic parameter access and drive command word block.
// Assumes one 100 MHz clock and a Modbus front end that hands over parsed requests.

`default_nettype none

package acyc_pkg;

  // --------------------------------------------------------------------------
  // Modbus function and exception codes
  // --------------------------------------------------------------------------
  localparam logic [7:0] FC_READ_HOLD   = 8'h03;
  localparam logic [7:0] FC_WR_SINGLE   = 8'h06;
  localparam logic [7:0] FC_WR_MULTI    = 8'h10;
  localparam logic [7:0] FC_RW_MULTI    = 8'h17;
  localparam logic [7:0] EXC_NONE       = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC   = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE  = 8'h03;

  // --------------------------------------------------------------------------
  // Non-cyclic address map
  // --------------------------------------------------------------------------
  localparam logic [15:0] NONCYC_BASE   = 16'h0210;
  localparam logic [15:0] ID_MENU_SCALE = 16'h0064;
  localparam logic [15:0] CW_MENU       = 16'h0006;
  localparam logic [15:0] CW_INDEX      = 16'h002A;
  localparam logic [7:0]  REGS_FOR_32   = 8'h02;
  localparam logic        REGS_SEL_RST  = 1'b1;

  // --------------------------------------------------------------------------
  // Command word layout
  // --------------------------------------------------------------------------
  localparam int CW_WIDTH     = 16;
  localparam int CW_ENABLE    = 0;
  localparam int CW_RUN_FWD   = 1;
  localparam int CW_JOG       = 2;
  localparam int CW_RUN_REV   = 3;
  localparam int CW_DIR       = 4;
  localparam int CW_RUN       = 5;
  localparam int CW_REF_SEL   = 8;
  localparam int CW_TRIP_RST  = 13;
  localparam logic [15:0] CW_USED_MASK = 16'h213F;
  localparam logic [15:0] CW_RST_VALUE = 16'h0000;

  // --------------------------------------------------------------------------
  // Speed reference selection
  // --------------------------------------------------------------------------
  localparam logic [3:0] PRESET_DEFAULT = 4'h1;
  localparam logic [3:0] PRESET_SEL_OFF = 4'h0;

endpackage

`default_nettype wire

// ===== hdl/param_addr_decode.sv
// Turns a non-cyclic Modbus register address into a parameter identifier.
// Purely combinational; the caller registers the result.

`timescale 1ns/10ps
`default_nettype none

module param_addr_decode (
  // Request address and mode
  input  wire logic [15:0] addr,
  input  wire logic        two_regs,
  input  wire logic        one_based,
  // Decode result
  output logic             in_area,
  output logic             aligned,
  output logic      [15:0] param_id
);

  // Local copy of the base so the offset logic reads a plain name
  localparam logic [15:0] NONCYC_BASE_W = acyc_pkg::NONCYC_BASE;

  logic [15:0] start;
  logic [15:0] rel;

  // --------------------------------------------------------------------------
  // Offset from the non-cyclic base
  // --------------------------------------------------------------------------
  // One-based masters shift the whole map up by one
  always_comb begin
    start   = NONCYC_BASE_W + {15'h0000, one_based};
    in_area = (addr >= start);
    rel     = addr - start;
  end

  // --------------------------------------------------------------------------
  // Identifier, i.e. menu*100+index, from the offset
  // --------------------------------------------------------------------------
  // Odd offsets in two-register mode hit the second half of a parameter
  always_comb begin
    if (two_regs) begin
      aligned  = ~rel[0];
      param_id = {1'b0, rel[15:1]} + 16'h0001;
    end else begin
      aligned  = 1'b1;
      param_id = rel + 16'h0001;
    end
  end

endmodule

`default_nettype wire

// ===== tb/plc_master_model.sv
// Master stand-in on the parsed request port: one request at a time.
// Assumes the block takes a request on ready and answers on the next edge.
`timescale 1ns/10ps
`default_nettype none
module plc_master_model (
  // Clock
  input  wire logic        clk,
  // Request side
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic      [7:0]  req_func,
  output logic      [15:0] req_addr,
  output logic      [7:0]  req_count,
  output logic      [31:0] req_wdata,
  // Answer side
  input  wire logic        resp_valid,
  input  wire logic [7:0]  resp_code,
  input  wire logic        param_wr,
  input  wire logic        param_rd,
  input  wire logic        map_clear,
  input  wire logic [15:0] param_id
);
  // Idle bus at time zero
  initial begin
    req_valid = 1'b0;
    {req_func, req_addr, req_count, req_wdata} = 64'h0;
  end

  // Register address of a parameter; a one-based master adds one
  function automatic logic [15:0] addr_of(input logic [15:0] n, input logic two,
                                          input logic ob);
    addr_of = 16'h0210 + (two ? (n - 16'h0001) << 1 : n - 16'h0001) + {15'h0, ob};
  endfunction

  // Hold request until taken, then sample the answer edge
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n,
                      input logic [31:0] d, output logic [31:0] res);
    int i;
    {req_func, req_addr, req_count, req_wdata} = {f, a, n, d};
    req_valid = 1'b1;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    // Released lines flip so a stale value is never mistaken for live data
    {req_func, req_addr, req_count, req_wdata} = ~{f, a, n, d};
    req_valid = 1'b0;
    @(posedge clk) #1;
    res = {resp_code, param_id, 4'h0, resp_valid, param_wr, param_rd, map_clear};
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_acyclic_param_access_ctrl_word.sv
// Bench for the acyclic access checker and command word decoder.
// Assumes the master model drives requests and a one-entry size table.
`timescale 1ns/10ps
`default_nettype none
module tb_acyclic_param_access_ctrl_word;
  logic        clk, srst, regs_per_param_select, master_one_based, cyclic_in_use;
  logic        cyclic_packing_enable, run_source_from_bus, safe_torque_in_a;
  logic        safe_torque_in_b, req_valid, req_ready, resp_valid, resp_exception;
  logic        param_wr, param_rd, map_clear, drive_enable_param, run_forward_param;
  logic        jog_param, run_reverse_param, direction_param, run_param, param_is_32;
  logic        digital_ref_select_param, trip_reset_param, external_safety_permit;
  logic [3:0]  preset_selector, active_preset;
  logic [7:0]  req_func, req_count, resp_code;
  logic [15:0] req_addr, lookup_id, param_id;
  logic [31:0] req_wdata, drive_command_word, res, param_wdata;
  logic [7:0]  outs;
  int          err_count, compares, cyc;

  // Only parameter 121 is 32 bits wide in this table
  assign param_is_32 = (lookup_id == 16'h0079);
  assign outs = {drive_enable_param, run_forward_param, jog_param, run_reverse_param,
                 direction_param, run_param, digital_ref_select_param, trip_reset_param};

  acyclic_param_ctrl DUT (.clk, .srst, .regs_per_param_select, .master_one_based,
    .cyclic_in_use, .cyclic_packing_enable, .run_source_from_bus, .preset_selector,
    .safe_torque_in_a, .safe_torque_in_b, .req_valid, .req_ready, .req_func, .req_addr,
    .req_count, .req_wdata, .lookup_id, .param_is_32, .resp_valid, .resp_exception,
    .resp_code, .param_wr, .param_rd, .param_id, .param_wdata, .map_clear,
    .drive_command_word, .drive_enable_param, .run_forward_param, .jog_param,
    .run_reverse_param, .direction_param, .run_param, .digital_ref_select_param,
    .active_preset, .trip_reset_param, .external_safety_permit);

  plc_master_model u_plc (.clk, .req_valid, .req_ready, .req_func, .req_addr,
    .req_count, .req_wdata, .resp_valid, .resp_code, .param_wr, .param_rd,
    .map_clear, .param_id);

  // ----------------------------------------------------------------------
  // Clock, watchdog and reporting
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is well under a thousand edges; this cuts a hung handshake
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic do_reset;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    chk("cw_reset", 32'h0, drive_command_word);
  endtask

  function automatic logic [15:0] ad(input logic [15:0] id);
    ad = u_plc.addr_of(id, regs_per_param_select, master_one_based);
  endfunction

  // Flags are {answer, write, read, map clear}
  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n,
                     input logic [7:0] code, input logic [3:0] fl, input logic [15:0] id);
    u_plc.xfer(f, a, n, 32'h0000_1234, res);
    chk("resp_code", {24'h0, code}, {24'h0, res[31:24]});
    chk("resp_flags", {28'h0, fl}, {28'h0, res[3:0]});
    chk("resp_exc", {31'h0, code != 8'h00}, {31'h0, resp_exception});
    if (code == 8'h00) begin
      chk("param_id", {16'h0, id}, {16'h0, res[23:8]});
      chk("param_wdata", 32'h0000_1234, param_wdata);
    end
  endtask

  function automatic logic [7:0] drv_exp(input logic [15:0] w, input logic tr);
    logic g;
    // Pins have stood still for many cycles, so the permit is their AND
    g = safe_torque_in_a & safe_torque_in_b & run_source_from_bus;
    drv_exp = {w[0] & g, w[1] & g, w[2] & g, w[3] & g, w[4] & run_source_from_bus,
               w[5] & g, w[8] & run_source_from_bus, w[13] & ~tr & run_source_from_bus};
  endfunction

  // Write the command word, then check decoded outputs and pulse end
  task automatic cw(input logic [15:0] w, input logic tr);
    u_plc.xfer(acyc_pkg::FC_WR_MULTI, ad(16'h0282), 8'h02, {16'h0, w}, res);
    chk("cw_code", 32'h0, {24'h0, res[31:24]});
    chk("cw_wdata", {16'h0, w}, param_wdata);
    @(posedge clk) #1;
    chk("cw_word", {16'h0, w}, drive_command_word);
    chk("drive_outs", {24'h0, drv_exp(w, tr)}, {24'h0, outs});
    @(posedge clk) #1;
    chk("trip_pulse", 32'h0, {31'h0, trip_reset_param});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {srst, master_one_based, cyclic_in_use, cyclic_packing_enable} = 4'h8;
    regs_per_param_select = 1'b1;
    {run_source_from_bus, safe_torque_in_a, safe_torque_in_b} = 3'h0;
    preset_selector = 4'h0;
    @(posedge clk) #1;
    // Every address mode, fresh reset each so the first access clears the map
    for (int m = 0; m < 4; m++) begin
      regs_per_param_select = m[1];
      master_one_based = m[0];
      do_reset();
      req(acyc_pkg::FC_READ_HOLD, ad(16'h0282), 8'h02, 8'h00, 4'hB, 16'h0282);
      req(acyc_pkg::FC_RW_MULTI, ad(16'h03FD), 8'h02, 8'h00, 4'hE, 16'h03FD);
      req(acyc_pkg::FC_WR_SINGLE, ad(16'h03FD), 8'h01, 8'h00, 4'hC, 16'h03FD);
      req(acyc_pkg::FC_WR_SINGLE, ad(16'h0079), 8'h02, 8'h03, 4'h8, 16'h0079);
      req(acyc_pkg::FC_WR_MULTI, ad(16'h0079), 8'h01, 8'h03, 4'h8, 16'h0079);
      req(acyc_pkg::FC_WR_MULTI, ad(16'h0079), 8'h02, m[1] ? 8'h00 : 8'h03,
          m[1] ? 4'hC : 4'h8, 16'h0079);
      req(acyc_pkg::FC_READ_HOLD, ad(16'h0282) + 16'h0001, 8'h02, m[1] ? 8'h02 : 8'h00,
          m[1] ? 4'h8 : 4'hA, 16'h0283);
      req(8'h04, ad(16'h0282), 8'h02, 8'h01, 4'h8, 16'h0282);
      req(acyc_pkg::FC_READ_HOLD, 16'h0100, 8'h02, 8'h02, 4'h8, 16'h0000);
    end
    // Cyclic exchange in use: first access leaves the mapping alone
    cyclic_in_use = 1'b1;
    do_reset();
    req(acyc_pkg::FC_READ_HOLD, ad(16'h0282), 8'h02, 8'h00, 4'hA, 16'h0282);
    // Command word with bus source and both safety inputs, then with input b low, then with the bus source off
    {cyclic_in_use, run_source_from_bus, safe_torque_in_a, safe_torque_in_b} = 4'h7;
    repeat (8) @(posedge clk) #1;
    chk("permit", 32'h1, {31'h0, external_safety_permit});
    cw(16'h2123, 1'b0);
    cw(16'h2123, 1'b1);
    cw(16'h000D, 1'b0);
    cw(16'h0130, 1'b0);
    chk("preset", 32'h1, {28'h0, active_preset});
    preset_selector = 4'h3;
    repeat (2) @(posedge clk) #1;
    chk("preset", 32'h3, {28'h0, active_preset});
    cyclic_packing_enable = 1'b1;
    cw(16'h0001, 1'b0);
    safe_torque_in_b = 1'b0;
    repeat (8) @(posedge clk) #1;
    chk("permit", 32'h0, {31'h0, external_safety_permit});
    cw(16'h0033, 1'b0);
    safe_torque_in_b = 1'b1;
    run_source_from_bus = 1'b0;
    repeat (8) @(posedge clk) #1;
    cw(16'h2133, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
